// >>> rtl/dmf_diag_flags.sv
// Purpose: Alarm and warning flags, limits, live values and transmitter disable control.
// Assumes: Byte-wide register port from the management logic, synchronous to clk.
// Notes:   Reads answer one cycle after the request; flags change only on an update.
`include "dmf_diag_flags_map.svh"

// Functional notes
// - Transmitter is off while software off bit or disable pin is high.
// - Rate choice pin never changes bandwidth; receiver stays at full bandwidth.
// - Alarm upper bit 7 set when temperature is above its high alarm limit.
// - Alarm upper bit 6 set when temperature is below its low alarm limit.
// - Alarm upper bits 5 and 4 flag supply voltage above high, below low.
// - Alarm upper bits 3 and 2 flag laser bias above high, below low.
// - Alarm upper bits 1 and 0 flag transmit power above high, below low.
// - Alarm lower bit 7 set when receive power is above its high alarm.
// - Alarm lower bit 6 flags receive power below low alarm; bits 0-5 reserved.
// - Warning upper bits 7 and 6 flag temperature above high, below low.
// - Warning upper bits 5 and 4 flag supply voltage above high, below low.
// - Warning upper bits 3 and 2 flag laser bias above high, below low.
// - Warning upper bits 1 and 0 flag transmit power above high, below low.
// - Warning lower bit 7 flags receive power above high; bits 0-5 reserved.
// - Warning lower bit 6 flags receive power below its low warning limit.
// - Host reads and writes the software off bit; it drives transmitter disable.
// - Temperature compares as signed 16 bit, other quantities as unsigned 16 bit.
module dmf_diag_flags (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    // Monitor update
    input  wire logic        monValid,
    input  wire logic [15:0] monTemp,
    input  wire logic [15:0] monVcc,
    input  wire logic [15:0] monBias,
    input  wire logic [15:0] monTxPwr,
    input  wire logic [15:0] monRxPwr,
    // Module pins
    input  wire logic        txDisablePin,
    input  wire logic        rateSelectPin,
    input  wire logic        txFaultIn,
    input  wire logic        losIn,
    output logic             txDisable,
    output logic             rxFullBandwidth
);

    // ==================================================================
    // Reset release
    logic                   syncMetan;
    logic                   syncResetn;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncMetan  <= 1'b0;
            syncResetn <= 1'b0;
        end else begin
            syncMetan  <= 1'b1;
            syncResetn <= syncMetan;
        end
    end

    // ==================================================================
    // State
    dmf_pkg::dmf_state_type st;
    dmf_pkg::dmf_state_type next_st;

    logic [15:0]            monVal [`DMF_CHANNELS];
    logic [15:0]            thrHiA [`DMF_CHANNELS];
    logic [15:0]            thrLoA [`DMF_CHANNELS];
    logic [15:0]            thrHiW [`DMF_CHANNELS];
    logic [15:0]            thrLoW [`DMF_CHANNELS];
    logic [15:0]            alarmNow;
    logic [15:0]            warnNow;
    logic [7:0]             readByte;
    logic [7:0]             rtIdx;

    assign monVal[0] = monTemp;
    assign monVal[1] = monVcc;
    assign monVal[2] = monBias;
    assign monVal[3] = monTxPwr;
    assign monVal[4] = monRxPwr;

    // ==================================================================
    // Limit comparison, one comparator per channel
    for (genvar c = 0; c < `DMF_CHANNELS; c++) begin : gChan
        localparam int B = c * `DMF_THR_PER_CH;

        assign thrHiA[c] = {st.thr[B],   st.thr[B+1]};
        assign thrLoA[c] = {st.thr[B+2], st.thr[B+3]};
        assign thrHiW[c] = {st.thr[B+4], st.thr[B+5]};
        assign thrLoW[c] = {st.thr[B+6], st.thr[B+7]};

        dmf_threshold_cmp uCmp (
            .isSigned     (c == `DMF_CH_TEMP),
            .value        (monVal[c]),
            .hiAlarm      (thrHiA[c]),
            .loAlarm      (thrLoA[c]),
            .hiWarn       (thrHiW[c]),
            .loWarn       (thrLoW[c]),
            .aboveHiAlarm (alarmNow[15-2*c]),
            .belowLoAlarm (alarmNow[14-2*c]),
            .aboveHiWarn  (warnNow[15-2*c]),
            .belowLoWarn  (warnNow[14-2*c])
        );
    end

    // Bit pairs run temperature, supply, bias, transmit, receive from the top.
    assign alarmNow[`DMF_RSVD_BITS-1:0] = 6'h00;
    assign warnNow[`DMF_RSVD_BITS-1:0]  = 6'h00;

    // ==================================================================
    // Read multiplexer
    assign rtIdx = regAddr - `DMF_RT_BASE;

    always_comb begin
        readByte = 8'h00;
        if (regAddr < `DMF_THR_END) begin
            readByte = st.thr[regAddr[5:0]];
        end else if (regAddr >= `DMF_RT_BASE && regAddr < `DMF_RT_END) begin
            readByte = rtIdx[0] ? st.mon[rtIdx[3:1]][7:0] : st.mon[rtIdx[3:1]][15:8];
        end else begin
            unique case (regAddr)
                `DMF_STATUS_ADDR: begin
                    readByte[`DMF_PIN_OFF_BIT]  = txDisablePin;
                    readByte[`DMF_SOFT_OFF_BIT] = st.softTxOff;
                    readByte[`DMF_RATE_BIT]     = rateSelectPin;
                    readByte[`DMF_FAULT_BIT]    = txFaultIn;
                    readByte[`DMF_LOS_BIT]      = losIn;
                    readByte[`DMF_NREADY_BIT]   = st.notReady;
                end
                `DMF_ALARM_UPPER: begin
                    readByte = st.alarm[15:8];
                end
                `DMF_ALARM_LOWER: begin
                    readByte = st.alarm[7:0];
                end
                `DMF_WARN_UPPER: begin
                    readByte = st.warn[15:8];
                end
                `DMF_WARN_LOWER: begin
                    readByte = st.warn[7:0];
                end
                default: begin
                    readByte = 8'h00;
                end
            endcase
        end
    end

    // ==================================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.rdData = 8'h00;
        // The pin is taken as already synchronous, so one flop suffices here.
        next_st.txDisable = st.softTxOff | txDisablePin;
        // Bandwidth is fixed; the rate pin only shows up in the status byte.
        next_st.fullBw = 1'b1;
        if (regWrite) begin
            if (regAddr < `DMF_THR_END) begin
                next_st.thr[regAddr[5:0]] = regWrData;
            end
            if (regAddr == `DMF_STATUS_ADDR) begin
                next_st.softTxOff = regWrData[`DMF_SOFT_OFF_BIT];
            end
        end
        if (regRead) begin
            next_st.rdData = readByte;
        end
        // Flags are compared against the live values so they match the update.
        if (monValid) begin
            for (int c = 0; c < `DMF_CHANNELS; c++) begin
                next_st.mon[c] = monVal[c];
            end
            next_st.alarm    = alarmNow;
            next_st.warn     = warnNow;
            next_st.notReady = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge syncResetn) begin
        if (!syncResetn) begin
            st <= dmf_pkg::DMF_RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // ==================================================================
    // Outputs
    assign regRdData       = st.rdData;
    assign txDisable       = st.txDisable;
    assign rxFullBandwidth = st.fullBw;

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!syncResetn);

    a_txdis_on:
        assert property ((txDisablePin || st.softTxOff) |=> txDisable)
        else $error("transmitter not disabled by pin or software bit");

    a_txdis_off:
        assert property ((!txDisablePin && !st.softTxOff) |=> !txDisable)
        else $error("transmitter disabled with both sources clear");

    a_rate_fixed:
        assert property ($changed(rateSelectPin) |=> rxFullBandwidth [*3])
        else $error("receiver bandwidth followed the rate pin");

    a_soft_write:
        assert property ((regWrite && regAddr == `DMF_STATUS_ADDR)
                         |=> ##1 txDisable == ($past(regWrData[6], 2) || $past(txDisablePin)))
        else $error("software off bit did not reach transmitter disable");

    a_soft_read:
        assert property ((regRead && regAddr == `DMF_STATUS_ADDR && !regWrite)
                         |=> regRdData[6] == $past(st.softTxOff))
        else $error("software off bit read back wrong");

    a_temp_hialarm:
        assert property (monValid |=> st.alarm[15] ==
                         ($signed($past(monTemp)) > $signed($past(thrHiA[0]))))
        else $error("temperature high alarm wrong");

    a_temp_loalarm:
        assert property (monValid |=> st.alarm[14] ==
                         ($signed($past(monTemp)) < $signed($past(thrLoA[0]))))
        else $error("temperature low alarm wrong");

    a_vcc_alarm:
        assert property (monValid |=> st.alarm[13:12] ==
                         {$past(monVcc) > $past(thrHiA[1]), $past(monVcc) < $past(thrLoA[1])})
        else $error("supply alarm flags wrong");

    a_bias_alarm:
        assert property (monValid |=> st.alarm[11:10] ==
                         {$past(monBias) > $past(thrHiA[2]), $past(monBias) < $past(thrLoA[2])})
        else $error("bias alarm flags wrong");

    a_txpwr_alarm:
        assert property (monValid |=> st.alarm[9:8] ==
                         {$past(monTxPwr) > $past(thrHiA[3]),
                          $past(monTxPwr) < $past(thrLoA[3])})
        else $error("transmit power alarm flags wrong");

    a_rxpwr_alarm:
        assert property (monValid |=> st.alarm[7:6] ==
                         {$past(monRxPwr) > $past(thrHiA[4]),
                          $past(monRxPwr) < $past(thrLoA[4])})
        else $error("receive power alarm flags wrong");

    a_rsvd_zero:
        assert property ((regRead && (regAddr == `DMF_ALARM_LOWER ||
                                      regAddr == `DMF_WARN_LOWER))
                         |=> (regRdData & `DMF_RSVD_MASK) == 8'h00)
        else $error("reserved flag bits read nonzero");

    a_temp_warn:
        assert property (monValid |=> st.warn[15:14] ==
                         {$signed($past(monTemp)) > $signed($past(thrHiW[0])),
                          $signed($past(monTemp)) < $signed($past(thrLoW[0]))})
        else $error("temperature warning flags wrong");

    a_mid_warn:
        assert property (monValid |=> st.warn[13:8] ==
                         {$past(monVcc) > $past(thrHiW[1]), $past(monVcc) < $past(thrLoW[1]),
                          $past(monBias) > $past(thrHiW[2]), $past(monBias) < $past(thrLoW[2]),
                          $past(monTxPwr) > $past(thrHiW[3]),
                          $past(monTxPwr) < $past(thrLoW[3])})
        else $error("supply, bias or transmit warning flags wrong");

    a_rx_warn:
        assert property (monValid |=> st.warn[7:0] ==
                         {$past(monRxPwr) > $past(thrHiW[4]),
                          $past(monRxPwr) < $past(thrLoW[4]), 6'h00})
        else $error("receive power warning flags wrong");

    a_flags_hold:
        assert property (!monValid |=> $stable(st.alarm) && $stable(st.warn))
        else $error("flags changed without a monitor update");

    a_flag_read:
        assert property ((regRead && regAddr == `DMF_ALARM_UPPER)
                         |=> regRdData == $past(st.alarm[15:8]))
        else $error("alarm upper byte read back wrong");

    // ==================================================================
    // Read path, warning flag, hold and capture checks

    a_alarm_lo_read:
        assert property ((regRead && regAddr == `DMF_ALARM_LOWER)
                         |=> regRdData == $past(st.alarm[7:0]))
        else $error("alarm lower byte read back wrong");

    a_warn_read:
        assert property ((regRead && regAddr == `DMF_WARN_UPPER)
                         |=> regRdData == $past(st.warn[15:8]))
        else $error("warning upper byte read back wrong");

    a_warn_lo_read:
        assert property ((regRead && regAddr == `DMF_WARN_LOWER)
                         |=> regRdData == $past(st.warn[7:0]))
        else $error("warning lower byte read back wrong");

    a_bias_warn:
        assert property (monValid |=> st.warn[11:10] ==
                         {$past(monBias) > $past(thrHiW[2]), $past(monBias) < $past(thrLoW[2])})
        else $error("bias warning flags wrong");

    a_txpwr_warn:
        assert property (monValid |=> st.warn[9:8] ==
                         {$past(monTxPwr) > $past(thrHiW[3]),
                          $past(monTxPwr) < $past(thrLoW[3])})
        else $error("transmit power warning flags wrong");

    a_rx_lowarn:
        assert property (monValid |=> st.warn[6] ==
                         ($past(monRxPwr) < $past(thrLoW[4])))
        else $error("receive power low warning wrong");

    a_read_idle:
        assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data not cleared after its cycle");

    a_flag_ro:
        assert property ((regWrite && regAddr == `DMF_ALARM_UPPER && !monValid)
                         |=> $stable(st.alarm))
        else $error("host write changed the alarm flags");

    a_soft_hold:
        assert property (!(regWrite && regAddr == `DMF_STATUS_ADDR)
                         |=> $stable(st.softTxOff))
        else $error("software off bit changed without a write");

    a_live_capture:
        assert property (monValid |=> st.mon[4] == $past(monRxPwr))
        else $error("receive power live value not captured");

endmodule : dmf_diag_flags

// >>> pkg/dmf_diag_flags_map.svh
// Purpose: Offsets, bit positions, reset values and counts of the diagnostic flag block.
// Assumes: Byte addresses of the diagnostic memory page, 8-bit data.
// Notes:   Definitions only.
`ifndef DMF_DIAG_FLAGS_MAP_SVH
`define DMF_DIAG_FLAGS_MAP_SVH

// ==================================================================
// Page layout
`define DMF_THR_BASE      8'h00
`define DMF_THR_END       8'h28
`define DMF_THR_BYTES     40
`define DMF_RT_BASE       8'h60
`define DMF_RT_END        8'h6A
`define DMF_STATUS_ADDR   8'h6E
`define DMF_ALARM_UPPER   8'h70
`define DMF_ALARM_LOWER   8'h71
`define DMF_WARN_UPPER    8'h74
`define DMF_WARN_LOWER    8'h75

// ==================================================================
// Status and control byte fields
`define DMF_PIN_OFF_BIT   7
`define DMF_SOFT_OFF_BIT  6
`define DMF_RATE_BIT      4
`define DMF_FAULT_BIT     2
`define DMF_LOS_BIT       1
`define DMF_NREADY_BIT    0

// ==================================================================
// Monitor channels and flag layout
`define DMF_CHANNELS      5
`define DMF_CH_TEMP       0
`define DMF_THR_PER_CH    8
`define DMF_RSVD_BITS     6
`define DMF_RSVD_MASK     8'h3F

// ==================================================================
// Threshold reset values, chosen so that no flag trips before setup
`define DMF_HI_RESET      16'hFFFF
`define DMF_LO_RESET      16'h0000
`define DMF_TEMP_HI_RESET 16'h7FFF
`define DMF_TEMP_LO_RESET 16'h8000

`endif

// >>> pkg/dmf_pkg.sv
// Purpose: Types and the reset state of the diagnostic flag block.
// Assumes: Constants come from the map header.
// Notes:   Thresholds are stored MSB first, four per channel.
`include "dmf_diag_flags_map.svh"

package dmf_pkg;

    typedef logic [7:0] dmf_byte_type;
    typedef dmf_byte_type [`DMF_THR_BYTES-1:0] dmf_thr_type;

    // ==================================================================
    // Whole register state of the flag block
    typedef struct packed {
        dmf_thr_type                    thr;
        logic [`DMF_CHANNELS-1:0][15:0] mon;
        logic [15:0]                    alarm;
        logic [15:0]                    warn;
        logic                           softTxOff;
        logic                           txDisable;
        logic                           fullBw;
        logic                           notReady;
        dmf_byte_type                   rdData;
    } dmf_state_type;

    function automatic dmf_thr_type dmf_thr_reset();
        dmf_thr_type t;
        logic [15:0] hi;
        logic [15:0] lo;
        t = '0;
        for (int c = 0; c < `DMF_CHANNELS; c++) begin
            hi = (c == `DMF_CH_TEMP) ? `DMF_TEMP_HI_RESET : `DMF_HI_RESET;
            lo = (c == `DMF_CH_TEMP) ? `DMF_TEMP_LO_RESET : `DMF_LO_RESET;
            for (int k = 0; k < 4; k++) begin
                t[c*8+k*2]   = (k[0] == 1'b0) ? hi[15:8] : lo[15:8];
                t[c*8+k*2+1] = (k[0] == 1'b0) ? hi[7:0]  : lo[7:0];
            end
        end
        return t;
    endfunction : dmf_thr_reset

    localparam dmf_state_type DMF_RESET_STATE = '{
        thr:       dmf_thr_reset(),
        mon:       '0,
        alarm:     16'h0000,
        warn:      16'h0000,
        softTxOff: 1'b0,
        txDisable: 1'b0,
        fullBw:    1'b1,
        notReady:  1'b1,
        rdData:    8'h00
    };

endpackage : dmf_pkg

// >>> rtl/dmf_threshold_cmp.sv
// Purpose: Compares one monitor value against its four stored limits.
// Assumes: Values and limits share one encoding, signed or unsigned.
// Notes:   Purely combinational; the caller registers the results.
module dmf_threshold_cmp (
    // Monitor value and its encoding
    input  wire logic        isSigned,
    input  wire logic [15:0] value,
    // Stored limits
    input  wire logic [15:0] hiAlarm,
    input  wire logic [15:0] loAlarm,
    input  wire logic [15:0] hiWarn,
    input  wire logic [15:0] loWarn,
    // Comparison results
    output logic             aboveHiAlarm,
    output logic             belowLoAlarm,
    output logic             aboveHiWarn,
    output logic             belowLoWarn
);

    // ==================================================================
    // One extra sign bit lets a single signed comparator serve both encodings.
    logic signed [16:0] v;
    logic signed [16:0] ha;
    logic signed [16:0] la;
    logic signed [16:0] hw;
    logic signed [16:0] lw;

    assign v  = {isSigned & value[15], value};
    assign ha = {isSigned & hiAlarm[15], hiAlarm};
    assign la = {isSigned & loAlarm[15], loAlarm};
    assign hw = {isSigned & hiWarn[15], hiWarn};
    assign lw = {isSigned & loWarn[15], loWarn};

    assign aboveHiAlarm = v > ha;
    assign belowLoAlarm = v < la;
    assign aboveHiWarn  = v > hw;
    assign belowLoWarn  = v < lw;

endmodule : dmf_threshold_cmp

// >>> tb/dmf_host_model.sv
// Purpose: Host controller model that drives the byte register port.
// Assumes: Requests are raised just after a rising edge and taken at the next one.
// Notes:   Read data is taken mid-cycle, while it still stands on the port.
module dmf_host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic      [7:0] regWrData,
    output logic            regRead,
    input  wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // Bus cycles
    initial begin
        regAddr   = 8'h00;
        regWrite  = 1'b0;
        regWrData = 8'h00;
        regRead   = 1'b0;
    end

    // Released lines show the inverse so a stale value never looks valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
        regAddr   <= ~a;
        regWrData <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(negedge clk);
        d = regRdData;
    endtask : rd
endmodule : dmf_host_model

// >>> tb/dmf_diag_flags_test.sv
// Purpose: Self-checking bench for the diagnostic flag block.
// Assumes: Host model drives the register port; the bench drives pins and monitors.
// Notes:   Expected flags are derived from limits kept in the bench.
module dmf_diag_flags_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // Signals
    logic        clk           = 1'b0;
    logic        resetn        = 1'b0;
    logic [7:0]  regAddr;
    logic        regWrite;
    logic [7:0]  regWrData;
    logic        regRead;
    logic [7:0]  regRdData;
    logic        monValid      = 1'b0;
    logic [15:0] mon [5]       = '{default: 16'h0000};
    logic        txDisablePin  = 1'b0;
    logic        rateSelectPin = 1'b0;
    logic        txFaultIn     = 1'b0;
    logic        losIn         = 1'b0;
    logic        txDisable;
    logic        rxFullBandwidth;
    logic [15:0] lim [5][4];
    logic [7:0]  fa [4]        = '{8'h70, 8'h71, 8'h74, 8'h75};
    int          errors        = 0;
    int          nTests        = 0;

    always #4 clk = ~clk;

    dmf_host_model i_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData));

    dmf_diag_flags i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
        .regRdData(regRdData), .monValid(monValid), .monTemp(mon[0]), .monVcc(mon[1]),
        .monBias(mon[2]), .monTxPwr(mon[3]), .monRxPwr(mon[4]),
        .txDisablePin(txDisablePin), .rateSelectPin(rateSelectPin),
        .txFaultIn(txFaultIn), .losIn(losIn), .txDisable(txDisable),
        .rxFullBandwidth(rxFullBandwidth));

    // ==================================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        nTests++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d, errors %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // Temperature is signed, everything else unsigned.
    function automatic logic gt(input int c, input logic [15:0] a, input logic [15:0] b);
        return (c == 0) ? ($signed(a) > $signed(b)) : (a > b);
    endfunction : gt

    function automatic logic [31:0] expect_flags(input logic [15:0] v [5]);
        logic [31:0] f;
        f = '0;
        for (int c = 0; c < 5; c++) begin
            for (int k = 0; k < 2; k++) begin
                f[31 - 16 * k - 2 * c] = gt(c, v[c], lim[c][2 * k]);
                f[30 - 16 * k - 2 * c] = gt(c, lim[c][2 * k + 1], v[c]);
            end
        end
        return f;
    endfunction : expect_flags

    function automatic logic [15:0] pick(input int c, input int j);
        case (j)
            0: return lim[c][0] + 16'h0001;
            1: return lim[c][1] - 16'h0001;
            2: return lim[c][2] + 16'h0001;
            3: return lim[c][3] - 16'h0001;
            4: return lim[c][0];
            5: return lim[c][1];
            default: return lim[c][3];
        endcase
    endfunction : pick

    task automatic pin_step(input logic p, input logic now, input logic after);
        @(posedge clk);
        txDisablePin  <= p;
        rateSelectPin <= ~rateSelectPin;
        @(negedge clk);
        check({7'h00, txDisable}, {7'h00, now});
        @(negedge clk);
        check({7'h00, txDisable}, {7'h00, after});
        check({7'h00, rxFullBandwidth}, 8'h01);
    endtask : pin_step

    // ==================================================================
    // Scenarios
    task automatic test_reset();
        logic [7:0] d;
        i_host.rd(8'h6E, d);
        check(d, 8'h01);
        for (int i = 0; i < 4; i++) begin
            i_host.rd(fa[i], d);
            check(d, 8'h00);
        end
        i_host.wr(8'h50, 8'hA5);
        i_host.rd(8'h50, d);
        check(d, 8'h00);
    endtask : test_reset

    task automatic test_txoff();
        pin_step(1'b1, 1'b0, 1'b1);
        pin_step(1'b0, 1'b1, 1'b0);
        i_host.wr(8'h6E, 8'h40);
        @(negedge clk);
        check({7'h00, txDisable}, 8'h00);
        @(negedge clk);
        check({7'h00, txDisable}, 8'h01);
        pin_step(1'b1, 1'b1, 1'b1);
        i_host.wr(8'h6E, 8'h00);
        pin_step(1'b0, 1'b1, 1'b0);
    endtask : test_txoff

    task automatic test_status();
        logic [7:0] d;
        @(posedge clk);
        txDisablePin  <= 1'b1;
        rateSelectPin <= 1'b1;
        txFaultIn     <= 1'b1;
        losIn         <= 1'b1;
        i_host.wr(8'h6E, 8'hFF);
        i_host.rd(8'h6E, d);
        check(d, 8'hD7);
        check({7'h00, rxFullBandwidth}, 8'h01);
        i_host.wr(8'h6E, 8'h00);
        pin_step(1'b0, 1'b1, 1'b0);
        @(posedge clk);
        txFaultIn <= 1'b0;
        losIn     <= 1'b0;
    endtask : test_status

    task automatic test_flags();
        logic [7:0]  d;
        logic [31:0] e;
        logic [15:0] v [5];
        for (int c = 0; c < 5; c++) begin
            if (c == 0) begin
                lim[c] = '{16'h1000, 16'hF000, 16'h0800, 16'hF800};
            end else begin
                lim[c] = '{16'h8000, 16'h2000, 16'h6000, 16'h4000};
            end
            for (int k = 0; k < 8; k++) begin
                i_host.wr(8'(c * 8 + k), k[0] ? lim[c][k / 2][7:0] : lim[c][k / 2][15:8]);
            end
        end
        i_host.rd(8'h0A, d);
        check(d, 8'h20);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            for (int c = 0; c < 5; c++) begin
                v[c] = pick(c, (i + c) % 7);
                mon[c] <= v[c];
            end
            monValid <= 1'b1;
            e = expect_flags(v);
            @(posedge clk);
            monValid <= 1'b0;
            for (int c = 0; c < 5; c++) begin
                mon[c] <= ~v[c];
            end
            i_host.wr(fa[i % 4], 8'hFF);
            i_host.rd(fa[0], d);
            check(d, e[31:24]);
            i_host.rd(fa[1], d);
            check(d, e[23:16]);
            i_host.rd(fa[2], d);
            check(d, e[15:8]);
            i_host.rd(fa[3], d);
            check(d, e[7:0]);
            i_host.rd(8'h60, d);
            check(d, v[0][15:8]);
        end
        i_host.rd(8'h6E, d);
        check(d, 8'h00);
    endtask : test_flags

    // ==================================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(negedge clk);
        check({7'h00, rxFullBandwidth}, 8'h01);
        @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset();
        test_txoff();
        test_status();
        test_flags();
        finish_test();
    end

    // The full run needs a few hundred cycles; this leaves ample margin.
    initial begin
        #100us;
        errors++;
        finish_test();
    end
endmodule : dmf_diag_flags_test
